/* File: flscmd_pkg.sv */
// flscmd_pkg: opcodes, field positions, reset values, timing and state types
// assumes: one core clock of 125 MHz; the host clocks the serial link far slower
package flscmd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEC_PROGRAM_TIME_NS = 1000;
  localparam int SEC_PROGRAM_CYCLES = (SEC_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_TIMER_W = 20;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_ID = 8'h9f;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5a;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_SET_READ_PARAMS = 8'hc0;
  localparam logic [7:0] OP_WRAP_SETUP = 8'h77;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_WRAP_READ = 8'h0c;

  // ----------------------------------------------------------------
  // counts, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] PARAM_TABLE_DUMMY = 4'h8;
  localparam logic [3:0] SEC_READ_DUMMY = 4'h8;
  localparam logic [3:0] SPI_FAST_DUMMY = 4'h8;
  localparam logic [3:0] DUMMY_BASE = 4'h2;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam logic [2:0] WRAP_SETUP_BYTES = 3'h3;
  localparam int DUMMY_FIELD_LSB = 4;
  localparam int WRAP_FIELD_LSB = 0;
  localparam int SPI_WRAP_LSB = 4;
  localparam logic [1:0] DUMMY_FIELD_RST = 2'h1;
  localparam logic [1:0] WRAP_FIELD_RST = 2'h0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam logic [3:0] SEC_AREA_FIRST = 4'h1;
  localparam logic [3:0] SEC_AREA_LAST = 4'h3;
  localparam int SEC_AREA_BYTES = 256;
  localparam int SEC_MEM_BYTES = 768;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] ID_LAST_IDX = 3'h2;
  localparam logic [3:0] SINGLE_OE_N = 4'hd;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_PROG, ST_ARM, ST_PARAM, ST_IGNORE
  } flscmd_state_t;

  typedef struct packed {
    flscmd_state_t state;
    logic four_wire_command_mode;
    logic sclk_prev;
    logic cs_prev;
    logic [7:0] in_sh;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [2:0] nbytes;
    logic [7:0] cmd;
    logic [31:0] addr;
    logic [3:0] dcnt;
    logic [3:0] dneed;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic oe;
    logic [3:0] pin;
    logic [3:0] pin_oe_n;
    logic write_permission_latch;
    logic busy;
    logic [BUSY_TIMER_W-1:0] btimer;
    logic [1:0] dummy_field;
    logic [1:0] wrap_field;
    logic prog_any;
    logic erase_go;
    logic wr_stb;
    logic [9:0] wr_idx;
    logic [7:0] wr_data;
    logic rd_stb;
  } flscmd_regs_t;

endpackage

/* File: flscmd_sync.sv */
// flscmd_sync: two-flop synchroniser for the serial link pins
// assumes: inputs are asynchronous to i_core_clk
`timescale 1ns/100ps
module flscmd_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } flscmd_sync_t;

  flscmd_sync_t q;
  flscmd_sync_t d;

  // ----------------------------------------------------------------
  // two stages, first read only by second
  // ----------------------------------------------------------------
  always_comb
  begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q <= '{s1: RST_VAL, s2: RST_VAL};
    end
    else if (i_clk_en)
    begin
      q <= d;
    end
  end

  assign o_sync = q.s2;

endmodule // flscmd_sync

/* File: flscmd_secmem.sv */
// flscmd_secmem: three 256-byte security areas held in flip-flops
// assumes: caller only presents indices of valid areas (0..767)
`timescale 1ns/100ps
module flscmd_secmem (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_wr_en,
  input wire logic [9:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  input wire logic i_erase_en,
  input wire logic [1:0] i_erase_area,
  input wire logic [9:0] i_rd_idx,
  output logic [7:0] o_rd_data
);

  typedef struct packed {
    logic [flscmd_pkg::SEC_MEM_BYTES-1:0][7:0] bytes;
  } flscmd_mem_t;

  flscmd_mem_t q;
  flscmd_mem_t d;

  // ----------------------------------------------------------------
  // erase whole area, program clears bits only
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (i_erase_en)
    begin
      for (int i = 0; i < flscmd_pkg::SEC_AREA_BYTES; i++)
      begin
        d.bytes[{i_erase_area, 8'(i)}] = flscmd_pkg::ERASED_BYTE;
      end
    end
    else if (i_wr_en)
    begin
      d.bytes[i_wr_idx] = q.bytes[i_wr_idx] & i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q <= '1;
    end
    else if (i_clk_en)
    begin
      q <= d;
    end
  end

  assign o_rd_data = q.bytes[i_rd_idx];

endmodule // flscmd_secmem

/* File: flscmd_top.sv */
// flscmd_top: serial flash command decoder for id, parameter table,
// security areas, read parameters and wrapped burst read
// assumes: serial clock well below an eighth of i_core_clk; array read
// data on i_array_data follows o_array_addr combinationally
`timescale 1ns/100ps
module flscmd_top #(
  parameter int SEC_ERASE_TIME_NS = 100000,
  parameter logic [7:0] MANUFACTURER_ID = 8'h3a, // arbitrary value
  parameter logic [7:0] MEMORY_TYPE_ID = 8'h71, // arbitrary value
  parameter logic [7:0] CAPACITY_ID = 8'h2d, // arbitrary value
  parameter logic [7:0][7:0] PARAMETER_TABLE_HEADER = 64'h0706050403020100
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic [3:0] i_spi_io,
  input wire logic i_four_wire_mode,
  input wire logic i_four_byte_addr,
  input wire logic [2:0] i_security_area_otp_locks,
  input wire logic i_param_restore,
  input wire logic [7:0] i_array_data,
  output logic [3:0] o_spi_io,
  output logic [3:0] o_spi_io_oe_n,
  output logic [31:0] o_array_addr,
  output logic o_array_rd,
  output logic o_busy,
  output logic o_write_permission_latch,
  output logic [1:0] o_dummy_count_field,
  output logic [1:0] o_wrap_length_field
);

  localparam int ERASE_CYCLES_I =
    (SEC_ERASE_TIME_NS + flscmd_pkg::CLK_PERIOD_NS - 1) / flscmd_pkg::CLK_PERIOD_NS;
  localparam logic [flscmd_pkg::BUSY_TIMER_W-1:0] ERASE_CYCLES =
    flscmd_pkg::BUSY_TIMER_W'(ERASE_CYCLES_I);
  localparam logic [flscmd_pkg::BUSY_TIMER_W-1:0] PROGRAM_CYCLES =
    flscmd_pkg::BUSY_TIMER_W'(flscmd_pkg::SEC_PROGRAM_CYCLES);

  localparam flscmd_pkg::flscmd_regs_t REGS_RST = '{
    state: flscmd_pkg::ST_IDLE,
    cs_prev: 1'b1,
    pin_oe_n: 4'hf,
    dummy_field: flscmd_pkg::DUMMY_FIELD_RST,
    wrap_field: flscmd_pkg::WRAP_FIELD_RST,
    default: '0
  };

  flscmd_pkg::flscmd_regs_t q;
  flscmd_pkg::flscmd_regs_t d;
  logic [5:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic [3:0] io_s;
  logic [7:0] sec_rd_data;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic sec_valid(input logic [31:0] a);
    sec_valid = (a[31:16] == 16'h0000) && (a[11:8] == 4'h0) &&
      (a[15:12] >= flscmd_pkg::SEC_AREA_FIRST) && (a[15:12] <= flscmd_pkg::SEC_AREA_LAST);
  endfunction

  function automatic logic [9:0] sec_idx(input logic [31:0] a);
    sec_idx = {2'(a[13:12] - 2'h1), a[7:0]};
  endfunction

  function automatic logic [1:0] sec_area(input logic [31:0] a);
    sec_area = 2'(a[13:12] - 2'h1);
  endfunction

  function automatic logic [31:0] next_addr(input logic [7:0] cmd, input logic [31:0] a,
                                            input logic [1:0] wrap);
    logic [31:0] mask;
    mask = {25'h0, 7'((8'h08 << wrap) - 8'h01)};
    next_addr = a + 32'h1;
    if (cmd == flscmd_pkg::OP_READ_ID)
    begin
      next_addr = (a[2:0] == flscmd_pkg::ID_LAST_IDX) ? 32'h0 : a + 32'h1;
    end
    else if ((cmd == flscmd_pkg::OP_SEC_READ) || (cmd == flscmd_pkg::OP_PARAM_TABLE))
    begin
      next_addr = {a[31:8], 8'(a[7:0] + 8'h01)};
    end
    else if (cmd == flscmd_pkg::OP_WRAP_READ)
    begin
      next_addr = (a & ~mask) | ((a + 32'h1) & mask);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and security storage
  // ----------------------------------------------------------------
  flscmd_sync #(
    .W(6),
    .RST_VAL(6'h20)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_async({i_spi_cs_n, i_spi_sclk, i_spi_io}),
    .o_sync(pins_s)
  );

  assign cs_n_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];

  flscmd_secmem u_secmem (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_wr_en(q.wr_stb),
    .i_wr_idx(q.wr_idx),
    .i_wr_data(q.wr_data),
    .i_erase_en(q.erase_go),
    .i_erase_area(sec_area(q.addr)),
    .i_rd_idx(sec_idx(q.addr)),
    .o_rd_data(sec_rd_data)
  );

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic cs_up;
    logic cs_dn;
    logic [2:0] last_bit;
    logic [7:0] in_byte;
    logic [7:0] src;
    logic [31:0] na;
    logic [3:0] cfg_dummy;
    rise = sclk_s & ~q.sclk_prev;
    fall = ~sclk_s & q.sclk_prev;
    cs_up = cs_n_s & ~q.cs_prev;
    cs_dn = ~cs_n_s & q.cs_prev;
    last_bit = q.four_wire_command_mode ? 3'h1 : 3'h7;
    in_byte = q.four_wire_command_mode ? {q.in_sh[3:0], io_s} : {q.in_sh[6:0], io_s[0]};
    na = {q.addr[23:0], in_byte};
    cfg_dummy = {1'b0, q.dummy_field, 1'b0} + flscmd_pkg::DUMMY_BASE;
    src = flscmd_pkg::ERASED_BYTE;
    d = q;
    d.sclk_prev = sclk_s;
    d.cs_prev = cs_n_s;
    d.erase_go = 1'b0;
    d.wr_stb = 1'b0;
    d.rd_stb = 1'b0;

    if (q.busy)
    begin
      if (q.btimer == '0)
      begin
        d.busy = 1'b0;
        d.write_permission_latch = 1'b0;
      end
      else
      begin
        d.btimer = q.btimer - 1'b1;
      end
    end

    if (i_param_restore)
    begin
      d.dummy_field = flscmd_pkg::DUMMY_FIELD_RST;
      d.wrap_field = flscmd_pkg::WRAP_FIELD_RST;
    end

    if (cs_up)
    begin
      d.state = flscmd_pkg::ST_IDLE;
      d.oe = 1'b0;
      if (q.state == flscmd_pkg::ST_ARM)
      begin
        d.erase_go = 1'b1;
        d.busy = 1'b1;
        d.btimer = ERASE_CYCLES;
      end
      else if ((q.state == flscmd_pkg::ST_PROG) && q.prog_any)
      begin
        d.busy = 1'b1;
        d.btimer = PROGRAM_CYCLES;
      end
    end
    else if (cs_dn)
    begin
      d.state = flscmd_pkg::ST_CMD;
      d.four_wire_command_mode = i_four_wire_mode;
      d.bit_cnt = 3'h0;
      d.byte_cnt = 3'h0;
      d.addr = 32'h0;
      d.prog_any = 1'b0;
      d.out_cnt = 3'h0;
      d.oe = 1'b0;
    end
    else if (rise)
    begin
      d.in_sh = in_byte;
      if ((q.state == flscmd_pkg::ST_CMD) || (q.state == flscmd_pkg::ST_ADDR) ||
          (q.state == flscmd_pkg::ST_PROG) || (q.state == flscmd_pkg::ST_PARAM))
      begin
        d.bit_cnt = (q.bit_cnt == last_bit) ? 3'h0 : q.bit_cnt + 3'h1;
      end
      case (q.state)
        flscmd_pkg::ST_CMD:
        begin
          if (q.bit_cnt == last_bit)
          begin
            d.cmd = in_byte;
            d.state = flscmd_pkg::ST_IGNORE;
            d.nbytes = i_four_byte_addr ? flscmd_pkg::ADDR_BYTES_4 : flscmd_pkg::ADDR_BYTES_3;
            if (!q.busy || (in_byte == flscmd_pkg::OP_READ_STATUS))
            begin
              case (in_byte)
                flscmd_pkg::OP_READ_STATUS: d.state = flscmd_pkg::ST_OUT;
                flscmd_pkg::OP_READ_ID: d.state = flscmd_pkg::ST_OUT;
                flscmd_pkg::OP_WRITE_ENABLE: d.write_permission_latch = 1'b1;
                flscmd_pkg::OP_WRITE_DISABLE: d.write_permission_latch = 1'b0;
                flscmd_pkg::OP_PARAM_TABLE:
                begin
                  d.state = flscmd_pkg::ST_ADDR;
                  d.nbytes = flscmd_pkg::ADDR_BYTES_3;
                end
                flscmd_pkg::OP_SEC_ERASE, flscmd_pkg::OP_SEC_PROGRAM:
                begin
                  if (!q.four_wire_command_mode && q.write_permission_latch)
                  begin
                    d.state = flscmd_pkg::ST_ADDR;
                  end
                end
                flscmd_pkg::OP_SEC_READ:
                begin
                  if (!q.four_wire_command_mode)
                  begin
                    d.state = flscmd_pkg::ST_ADDR;
                  end
                end
                flscmd_pkg::OP_FAST_READ: d.state = flscmd_pkg::ST_ADDR;
                flscmd_pkg::OP_QUAD_IO_READ, flscmd_pkg::OP_WRAP_READ:
                begin
                  if (q.four_wire_command_mode)
                  begin
                    d.state = flscmd_pkg::ST_ADDR;
                  end
                end
                flscmd_pkg::OP_SET_READ_PARAMS:
                begin
                  if (q.four_wire_command_mode)
                  begin
                    d.state = flscmd_pkg::ST_PARAM;
                  end
                end
                flscmd_pkg::OP_WRAP_SETUP:
                begin
                  if (!q.four_wire_command_mode)
                  begin
                    d.state = flscmd_pkg::ST_ADDR;
                    d.nbytes = flscmd_pkg::WRAP_SETUP_BYTES;
                  end
                end
                default: d.state = flscmd_pkg::ST_IGNORE;
              endcase
            end
          end
        end
        flscmd_pkg::ST_ADDR:
        begin
          if (q.bit_cnt == last_bit)
          begin
            d.addr = na;
            d.byte_cnt = q.byte_cnt + 3'h1;
            d.dcnt = 4'h0;
            if (q.byte_cnt == q.nbytes - 3'h1)
            begin
              d.state = flscmd_pkg::ST_DUMMY;
              case (q.cmd)
                flscmd_pkg::OP_PARAM_TABLE: d.dneed = flscmd_pkg::PARAM_TABLE_DUMMY;
                flscmd_pkg::OP_SEC_READ: d.dneed = flscmd_pkg::SEC_READ_DUMMY;
                flscmd_pkg::OP_FAST_READ:
                begin
                  d.dneed = q.four_wire_command_mode ? cfg_dummy : flscmd_pkg::SPI_FAST_DUMMY;
                end
                flscmd_pkg::OP_QUAD_IO_READ, flscmd_pkg::OP_WRAP_READ:
                begin
                  d.dneed = cfg_dummy;
                end
                flscmd_pkg::OP_SEC_ERASE:
                begin
                  d.state = flscmd_pkg::ST_IGNORE;
                  if (sec_valid(na) && !i_security_area_otp_locks[sec_area(na)])
                  begin
                    d.state = flscmd_pkg::ST_ARM;
                  end
                end
                flscmd_pkg::OP_SEC_PROGRAM:
                begin
                  d.state = flscmd_pkg::ST_IGNORE;
                  if (sec_valid(na) && !i_security_area_otp_locks[sec_area(na)])
                  begin
                    d.state = flscmd_pkg::ST_PROG;
                  end
                end
                default: d.state = flscmd_pkg::ST_PARAM;
              endcase
            end
          end
        end
        flscmd_pkg::ST_DUMMY:
        begin
          d.dcnt = q.dcnt + 4'h1;
          if (q.dcnt == q.dneed - 4'h1)
          begin
            d.state = flscmd_pkg::ST_OUT;
            d.out_cnt = 3'h0;
          end
        end
        flscmd_pkg::ST_PROG:
        begin
          if (q.bit_cnt == last_bit)
          begin
            d.wr_stb = 1'b1;
            d.wr_idx = sec_idx(q.addr);
            d.wr_data = in_byte;
            d.addr = {q.addr[31:8], 8'(q.addr[7:0] + 8'h01)};
            d.prog_any = 1'b1;
          end
        end
        flscmd_pkg::ST_ARM: d.state = flscmd_pkg::ST_IGNORE;
        flscmd_pkg::ST_PARAM:
        begin
          if (q.bit_cnt == last_bit)
          begin
            d.state = flscmd_pkg::ST_IGNORE;
            if (q.cmd == flscmd_pkg::OP_SET_READ_PARAMS)
            begin
              d.dummy_field = in_byte[flscmd_pkg::DUMMY_FIELD_LSB +: 2];
              d.wrap_field = in_byte[flscmd_pkg::WRAP_FIELD_LSB +: 2];
            end
            else
            begin
              d.wrap_field = in_byte[flscmd_pkg::SPI_WRAP_LSB +: 2];
            end
          end
        end
        default: d.state = q.state;
      endcase
    end
    else if (fall && (q.state == flscmd_pkg::ST_OUT))
    begin
      d.out_cnt = (q.out_cnt == last_bit) ? 3'h0 : q.out_cnt + 3'h1;
      if (q.out_cnt == 3'h0)
      begin
        case (q.cmd)
          flscmd_pkg::OP_READ_STATUS:
          begin
            src = 8'h00;
            src[flscmd_pkg::STATUS_BUSY_BIT] = q.busy;
            src[flscmd_pkg::STATUS_WEL_BIT] = q.write_permission_latch;
          end
          flscmd_pkg::OP_READ_ID:
          begin
            src = (q.addr[1:0] == 2'h0) ? MANUFACTURER_ID :
                  (q.addr[1:0] == 2'h1) ? MEMORY_TYPE_ID : CAPACITY_ID;
          end
          flscmd_pkg::OP_PARAM_TABLE:
          begin
            if ((q.addr[23:8] == 16'h0000) && (q.addr[7:3] == 5'h00))
            begin
              src = PARAMETER_TABLE_HEADER[q.addr[2:0]];
            end
          end
          flscmd_pkg::OP_SEC_READ:
          begin
            if (sec_valid(q.addr))
            begin
              src = sec_rd_data;
            end
          end
          default:
          begin
            src = i_array_data;
            d.rd_stb = 1'b1;
          end
        endcase
        d.out_sh = src;
        d.oe = 1'b1;
        d.addr = next_addr(q.cmd, q.addr, q.wrap_field);
      end
      else
      begin
        d.out_sh = q.four_wire_command_mode ? {q.out_sh[3:0], 4'h0} : {q.out_sh[6:0], 1'b0};
      end
    end

    d.pin = q.four_wire_command_mode ? d.out_sh[7:4] : {2'b00, d.out_sh[7], 1'b0};
    d.pin_oe_n = !d.oe ? 4'hf : (q.four_wire_command_mode ? 4'h0 : flscmd_pkg::SINGLE_OE_N);
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q <= REGS_RST;
    end
    else if (i_clk_en)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_spi_io = q.pin;
  assign o_spi_io_oe_n = q.pin_oe_n;
  assign o_array_addr = q.addr;
  assign o_array_rd = q.rd_stb;
  assign o_busy = q.busy;
  assign o_write_permission_latch = q.write_permission_latch;
  assign o_dummy_count_field = q.dummy_field;
  assign o_wrap_length_field = q.wrap_field;

endmodule // flscmd_top

/* File: flscmd_chk.sv */
// flscmd_chk: concurrent checks on the ports of flscmd_top
// assumes: bound to flscmd_top, erase time parameter handed on
`timescale 1ns/100ps
module flscmd_chk #(
  parameter int SEC_ERASE_TIME_NS = 100000
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_spi_cs_n,
  input wire logic i_four_wire_mode,
  input wire logic i_param_restore,
  input wire logic [3:0] o_spi_io_oe_n,
  input wire logic o_busy,
  input wire logic o_write_permission_latch,
  input wire logic [1:0] o_dummy_count_field,
  input wire logic [1:0] o_wrap_length_field
);
  // ----------------------------------------------------------------
  // busy length counter and checks
  // ----------------------------------------------------------------
  localparam int ERASE_CYC = (SEC_ERASE_TIME_NS + 7) / 8 + 1;
  logic [15:0] bcnt_q;
  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
      bcnt_q <= 16'h0;
    else
      bcnt_q <= o_busy ? bcnt_q + 16'h1 : 16'h0;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_reset_defaults: assert property ($fell(i_reset) |-> {o_dummy_count_field,
    o_wrap_length_field, o_busy, o_write_permission_latch} == 6'h10) else $error("bad reset");
  a_restore_vals: assert property (i_param_restore |=> o_dummy_count_field == 2'h1
    && o_wrap_length_field == 2'h0) else $error("restore missed");
  a_param_mode: assert property ($changed(o_dummy_count_field) |->
    $past(i_four_wire_mode) || $past(i_param_restore)) else $error("set in single mode");
  a_busy_len: assert property ($fell(o_busy) |->
    bcnt_q == ERASE_CYC || bcnt_q == 126) else $error("busy length wrong");
  a_wel_clear: assert property ($fell(o_busy) |-> !o_write_permission_latch)
    else $error("latch kept");
  a_wel_needed: assert property ($rose(o_busy) |-> $past(o_write_permission_latch))
    else $error("busy without latch");
  a_busy_hold: assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("busy dropped early");
  a_oe_idle: assert property (i_spi_cs_n [*6] |-> o_spi_io_oe_n == 4'hf)
    else $error("driving while deselected");
endmodule // flscmd_chk
bind flscmd_top flscmd_chk #(.SEC_ERASE_TIME_NS(SEC_ERASE_TIME_NS)) flscmd_chk_i (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_spi_cs_n(i_spi_cs_n),
  .i_four_wire_mode(i_four_wire_mode), .i_param_restore(i_param_restore),
  .o_spi_io_oe_n(o_spi_io_oe_n), .o_busy(o_busy),
  .o_write_permission_latch(o_write_permission_latch),
  .o_dummy_count_field(o_dummy_count_field), .o_wrap_length_field(o_wrap_length_field));

/* File: flscmd_host.sv */
// flscmd_host: host side of the serial link, select, clock and data
// assumes: serial clock half period of 8 core cycles, idle low
`timescale 1ns/100ps
module flscmd_host (
  input wire logic i_clk,
  input wire logic [3:0] i_sdo,
  input wire logic i_qm,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_sio,
  output logic [7:0] o_rbyte,
  output logic o_rvld
);
  // ----------------------------------------------------------------
  // frame tasks
  // ----------------------------------------------------------------
  initial {o_cs_n, o_sclk, o_sio, o_rbyte, o_rvld} = 15'h4000;
  task automatic xb(input logic [7:0] b, input logic rd);
    logic [7:0] r;
    for (int i = 0; i < (i_qm ? 2 : 8); i++)
    begin
      o_sio = i_qm ? (i == 0 ? b[7:4] : b[3:0]) : {3'h0, b[7-i]};
      repeat (8) @(negedge i_clk);
      o_sclk = 1'b1;
      r = i_qm ? {r[3:0], i_sdo} : {r[6:0], i_sdo[1]};
      repeat (8) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    o_rbyte = r;
    o_rvld = rd;
    @(negedge i_clk);
    o_rvld = 1'b0;
  endtask
  task automatic frame(input logic [7:0] q[$], input int nrd);
    o_cs_n = 1'b0;
    repeat (8) @(negedge i_clk);
    foreach (q[k]) xb(q[k], 1'b0);
    repeat (nrd) xb({~o_sio, ~o_sio}, 1'b1);
    repeat (8) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_sio = ~o_sio;
    repeat (8) @(negedge i_clk);
  endtask
endmodule // flscmd_host

/* File: tb_top.sv */
// tb_top: self-checking bench for flscmd_top driven by the host model
// assumes: erase time shortened to 12000 ns, default table header
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic qm = 1'b0;
  logic fb = 1'b0;
  logic rs = 1'b0;
  logic [2:0] lk = 3'h0;
  logic cs_n, sclk, rv, busy, write_permission_latch, ard;
  logic [3:0] sio, so, soe_n;
  logic [7:0] rb, a, d1, d2;
  logic [31:0] aa;
  logic [1:0] dmy, wrp;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int n_rd = 0;
  always #4 clk = ~clk;
  always @(negedge clk) if (ard) n_rd++;
  flscmd_top #(.SEC_ERASE_TIME_NS(12000)) flscmd_top_i (.i_core_clk(clk), .i_reset(rst),
    .i_clk_en(1'b1), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_io(sio),
    .i_four_wire_mode(qm), .i_four_byte_addr(fb), .i_security_area_otp_locks(lk),
    .i_param_restore(rs), .i_array_data(aa[7:0] ^ 8'h5a), .o_spi_io(so),
    .o_spi_io_oe_n(soe_n), .o_array_addr(aa), .o_array_rd(ard), .o_busy(busy),
    .o_write_permission_latch(write_permission_latch), .o_dummy_count_field(dmy), .o_wrap_length_field(wrp));
  flscmd_host flscmd_host_i (.i_clk(clk), .i_sdo(so ^ soe_n), .i_qm(qm), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_sio(sio), .o_rbyte(rb), .o_rvld(rv));
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
    if (rv)
      check(rb, exp_q.pop_front());
  initial
  begin
    #400000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'hf880a79d));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check({4'h0, dmy, wrp}, 8'h04);
    exp_q = '{8'h3a, 8'h71, 8'h2d, 8'h3a};
    flscmd_host_i.frame('{8'h9f}, 4);
    a = 8'($urandom) & 8'h0f;
    fb = 1'b1;
    exp_q = '{(a < 8) ? a : 8'hff, (a < 7) ? a + 8'h1 : 8'hff, 8'hff};
    flscmd_host_i.frame('{8'h5a, 8'h00, 8'h00, a, 8'h00}, 2);
    flscmd_host_i.frame('{8'h5a, 8'h00, 8'h01, 8'h00, 8'h00}, 1);
    fb = 1'b0;
    $display("test id and table done");
    flscmd_host_i.frame('{8'h44, 8'h00, 8'h20, 8'h00}, 0);
    check({7'h0, busy}, 8'h00);
    flscmd_host_i.frame('{8'h06}, 0);
    lk = 3'h1;
    flscmd_host_i.frame('{8'h44, 8'h00, 8'h10, 8'h00}, 0);
    flscmd_host_i.frame('{8'h44, 8'h00, 8'h20, 8'h00, 8'h00}, 0);
    exp_q.push_back(8'h02);
    flscmd_host_i.frame('{8'h05}, 1);
    flscmd_host_i.frame('{8'h44, 8'h00, 8'h20, 8'h00}, 0);
    exp_q.push_back(8'h03);
    flscmd_host_i.frame('{8'h05}, 1);
    flscmd_host_i.frame('{8'h48, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00}, 0);
    check({7'h0, busy}, 8'h01);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clk);
    exp_q.push_back(8'h00);
    flscmd_host_i.frame('{8'h05}, 1);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    flscmd_host_i.frame('{8'h06}, 0);
    flscmd_host_i.frame('{8'h42, 8'h00, 8'h20, 8'hff, d1, d2}, 0);
    for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk);
    flscmd_host_i.frame('{8'h06}, 0);
    flscmd_host_i.frame('{8'h42, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
    check({6'h0, busy, write_permission_latch}, 8'h01);
    exp_q = '{d1, d2, 8'hff};
    flscmd_host_i.frame('{8'h48, 8'h00, 8'h20, 8'hff, 8'h00}, 3);
    $display("test security areas done");
    qm = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      flscmd_host_i.frame('{8'hc0, 8'(15 * i + 3)}, 0);
      check({4'h0, dmy, wrp}, 8'(3 * i + 3));
    end
    flscmd_host_i.frame('{8'hc0, 8'h00}, 0);
    exp_q = '{8'h5e, 8'h5f, 8'h5c, 8'h5d, 8'h5a};
    flscmd_host_i.frame('{8'h0c, 8'h00, 8'h00, 8'h04, 8'h00}, 5);
    check(8'(n_rd), 8'h06);
    qm = 1'b0;
    flscmd_host_i.frame('{8'hc0, 8'h31}, 0);
    check({4'h0, dmy, wrp}, 8'h00);
    flscmd_host_i.frame('{8'h77, 8'h00, 8'h00, 8'h00, 8'h20}, 0);
    qm = 1'b1;
    check({6'h0, wrp}, 8'h02);
    rs = 1'b1;
    @(negedge clk);
    rs = 1'b0;
    check({4'h0, dmy, wrp}, 8'h04);
    check(8'(exp_q.size()), 8'h00);
    $display("test read parameters done");
    stop_test();
  end
endmodule // tb_top
